// ==== tb/mlp_ctrl_props.sv ====
// Checker of the power mode behaviour at the control block's ports.
`timescale 1ns/100ps
module mlp_ctrl_props
	import mlp_pkg::*;
#(parameter int THPLP_CYC = MLP_THPLP_CYC)(
	input wire logic       CLK,
	input wire logic       RSTN,
	input wire logic       MODULE_LOWPOWER_REQ_N,
	input wire logic       MODULE_SIDE_RESET_N,
	input wire logic       COMPARATOR_FITTED,
	input wire logic [2:0] RATED_CLASS,
	input wire logic [2:0] POWER_CLASS,
	input wire logic       HIGH_POWER_EN,
	input wire logic       TX_DISABLE
);
	int lo_q;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// Counts a held request; the shed limit runs from the pin, not the sync.
	always_ff @(posedge CLK or negedge RSTN)
		if (!RSTN) lo_q <= 0;
		else lo_q <= MODULE_LOWPOWER_REQ_N ? 0 : lo_q + 1;
	lp_tx_a:
		assert property (!MODULE_LOWPOWER_REQ_N [*4] |-> TX_DISABLE)
		else $error("tx on in low power");
	rst_tx_a:
		assert property (!MODULE_SIDE_RESET_N [*4] |-> TX_DISABLE)
		else $error("tx on in reset");
	hp_gate_a:
		assert property ($rose(HIGH_POWER_EN) |-> $past(MODULE_LOWPOWER_REQ_N,
			16) && $past(MODULE_SIDE_RESET_N, 16)) else $error("early high");
	class_cap_a:
		assert property (POWER_CLASS == MLP_CLASS_1 ||
			POWER_CLASS <= RATED_CLASS) else $error("class above rating");
	hpe_class_a:
		assert property (POWER_CLASS != MLP_CLASS_1 |-> HIGH_POWER_EN)
		else $error("high class without enable");
	shed_time_a:
		assert property (lo_q >= THPLP_CYC |-> POWER_CLASS == MLP_CLASS_1 &&
			!HIGH_POWER_EN) else $error("shed too slow");
	no_fit_a:
		assert property (!COMPARATOR_FITTED [*4] ##0 POWER_CLASS ==
			MLP_CLASS_1 |=> POWER_CLASS == MLP_CLASS_1) else $error("no fit");
	rst_hold_a:
		assert property (!MODULE_SIDE_RESET_N [*4] ##0 POWER_CLASS ==
			MLP_CLASS_1 |=> POWER_CLASS == MLP_CLASS_1) else $error("reset");
	cover property ($rose(HIGH_POWER_EN));
	cover property (POWER_CLASS == MLP_CLASS_MAX);
	cover property ($fell(HIGH_POWER_EN));
endmodule
bind mlp_ctrl mlp_ctrl_props #(.THPLP_CYC(THPLP_CYC)) i_mlp_ctrl_props (
	.CLK(CLK), .RSTN(RSTN), .MODULE_LOWPOWER_REQ_N(MODULE_LOWPOWER_REQ_N),
	.MODULE_SIDE_RESET_N(MODULE_SIDE_RESET_N), .TX_DISABLE(TX_DISABLE),
	.COMPARATOR_FITTED(COMPARATOR_FITTED), .RATED_CLASS(RATED_CLASS),
	.POWER_CLASS(POWER_CLASS), .HIGH_POWER_EN(HIGH_POWER_EN));

// ==== tb/mlp_ctrl_tb.sv ====
// Self-checking bench for the power mode control block.
`timescale 1ns/100ps
module mlp_ctrl_tb;
	import mlp_pkg::*;
	logic        clk, rstn, hp, slow, rst_n, fit, txr, hpe, txd, late;
	logic [2:0]  rated, pcls;
	logic [7:0]  addr, rdata;
	wire logic   lp_n;
	int          failures, compares, cyc;
	logic [15:0] rows [3] = '{16'h8302, 16'h0000, 16'h8400};
	mlp_host i_mlp_host (.clk(clk), .hp(hp), .slow(slow), .lp_n(lp_n));
	mlp_ctrl #(.THPLP_CYC(100)) i_mlp_ctrl (.CLK(clk), .RSTN(rstn),
		.MODULE_LOWPOWER_REQ_N(lp_n), .MODULE_SIDE_RESET_N(rst_n),
		.COMPARATOR_FITTED(fit), .RATED_CLASS(rated), .TX_DISABLE_REG(txr),
		.MGMT_ADDR(addr), .MGMT_RDATA(rdata), .POWER_CLASS(pcls),
		.HIGH_POWER_EN(hpe), .TX_DISABLE(txd), .TRANSITION_LATE(late));
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
		if (++cyc == 4000) begin
			failures++;
			summarize();
		end
	task automatic summarize;
		if (failures == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	initial begin
		{rstn, hp, slow, txr, rst_n, fit} = 6'h03;
		{rated, addr} = 11'h200;
		tick(6);
		chk({2'h0, pcls, hpe, txd, late}, 8'h0a);
		rstn = 1;
		foreach (rows[i]) begin
			addr = rows[i][15:8];
			tick(1);
			chk(rdata, rows[i][7:0]);
		end
		for (int k = 0; k < 2; k++) begin
			{rated, slow, hp} = k ? 5'h17 : 5'h09;
			for (int n = 0; n < 120 && pcls !== rated; n++)
				tick(1);
			// The high state begins one full step after the last class rise.
			tick(MLP_STEP_CYC + 1);
			chk({4'h0, pcls, txd}, {4'h0, rated, 1'b0});
			txr = 1;
			tick(1);
			chk({7'h0, txd}, 8'h01);
			txr = 0;
			tick(1);
			chk({7'h0, txd}, 8'h00);
			{hp, rst_n} = k ? 2'h2 : 2'h1;
			tick(5);
			chk({7'h0, txd}, 8'h01);
			tick(95);
			chk({2'h0, pcls, hpe, txd, late}, 8'h0a);
			{hp, rst_n} = 2'h1;
			tick(1);
		end
		{fit, hp} = 2'h1;
		tick(60);
		chk({2'h0, pcls, hpe, txd, late}, 8'h0a);
		// Reset in mid-run from full power, then a fresh climb.
		{fit, addr} = 9'h183;
		for (int n = 0; n < 120 && pcls !== rated; n++)
			tick(1);
		chk(rdata, {5'h0, rated});
		rstn = 0;
		tick(1);
		chk({2'h0, pcls, hpe, txd, late}, 8'h0a);
		chk(rdata, 8'h00);
		rstn = 1;
		tick(2);
		chk({2'h0, pcls, hpe, txd, late}, 8'h0a);
		tick(MLP_STEP_CYC + 1);
		chk({4'h0, pcls, hpe}, 8'h05);
		summarize();
	end
endmodule

// ==== tb/mlp_host.sv ====
// Host controller model driving the low-power request line.
`timescale 1ns/100ps
module mlp_host (
	input  wire logic clk,
	input  wire logic hp,
	input  wire logic slow,
	output logic      lp_n
);
	logic [1:0] d_q;
	always_ff @(posedge clk) d_q <= {d_q[0], hp};
	// A slow host reaches the line two cycles after its decision.
	assign lp_n = slow ? d_q[1] : hp;
endmodule

// ==== verilog/mlp_ctrl.sv ====
// Module-side power mode control driven by the low-power and reset inputs.
//
// Operation
// - Low-power active drops to class one, transmitters off, in time.
// - High-to-low transition finishes within 200 microseconds.
// - Low-power or reset asserted forces the lowest power class.
// - Transmitters stay disabled while low-power or reset is asserted.
// - Classes two to five only once both inputs are deasserted.
// - Class one is the default state in reset or low power.
// - Never draw more than the self-reported power class.
// - Line zones: low power, high power, module absent.
// - Comparators at 2.5 V for presence, 1.25 V for low power.
// - Lost contact reads as low-power asserted via the pull-down.
// - Grounded-pin module without comparator stays in class one.
// - No transmitter-disable pin; register or low-power disables them.
`timescale 1ns/100ps
module mlp_ctrl
	import mlp_pkg::*;
#(
	parameter int THPLP_CYC = MLP_THPLP_CYC
)(
	input  wire logic       CLK,
	input  wire logic       RSTN,
	input  wire logic       MODULE_LOWPOWER_REQ_N,
	input  wire logic       MODULE_SIDE_RESET_N,
	input  wire logic       COMPARATOR_FITTED,
	input  wire logic [2:0] RATED_CLASS,
	input  wire logic       TX_DISABLE_REG,
	input  wire logic [7:0] MGMT_ADDR,
	output logic [7:0]      MGMT_RDATA,
	output logic [2:0]      POWER_CLASS,
	output logic            HIGH_POWER_EN,
	output logic            TX_DISABLE,
	output logic            TRANSITION_LATE
);
	mlp_sync_if sync ();

	mlp_sync u_sync (
		.clk           (CLK),
		.rst_n         (RSTN),
		.lowpower_n_in (MODULE_LOWPOWER_REQ_N),
		.reset_n_in    (MODULE_SIDE_RESET_N),
		.sync          (sync)
	);

	// Rated class limited to the legal range; bad values fall to class one.
	function automatic logic [2:0] legal_class(input logic [2:0] c);
		if (c >= MLP_CLASS_1 && c <= MLP_CLASS_MAX)
			legal_class = c;
		else
			legal_class = MLP_CLASS_1;
	endfunction

	mlp_state_t state_q;
	mlp_state_t state_d;
	logic [4:0] step_q;
	logic [4:0] step_d;
	logic [2:0] class_q;
	logic [2:0] class_d;
	logic       hpen_q;
	logic       hpen_d;
	logic       txdis_q;
	logic       txdis_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [16:0] wdog_q;
	logic [16:0] wdog_d;
	logic       late_q;
	logic       late_d;
	logic       lp_active;
	logic [2:0] target;

	// A module with no comparator has the pin grounded: always low power.
	always_comb begin
		lp_active = !sync.lowpower_n || !sync.reset_n ||
			!COMPARATOR_FITTED;
		target    = legal_class(RATED_CLASS);
	end

	always_comb begin
		state_d = state_q;
		step_d  = step_q;
		class_d = class_q;
		hpen_d  = hpen_q;
		txdis_d = txdis_q;
		case (state_q)
			MLP_LOW: begin
				class_d = MLP_CLASS_1;
				hpen_d  = 1'b0;
				txdis_d = 1'b1;
				if (!lp_active) begin
					state_d = MLP_RAMP;
					step_d  = 5'h0;
				end
			end
			MLP_RAMP: begin
				// Stepping up one class at a time keeps inrush slopes gentle.
				if (lp_active) begin
					state_d = MLP_SHED;
					txdis_d = 1'b1;
					step_d  = 5'h0;
				end else if (step_q == MLP_STEP_LAST) begin
					step_d = 5'h0;
					if (class_q < target) begin
						class_d = class_q + 3'h1;
						hpen_d  = 1'b1;
					end else begin
						state_d = MLP_HIGH;
					end
				end else begin
					step_d = step_q + 5'h1;
				end
			end
			MLP_HIGH: begin
				txdis_d = TX_DISABLE_REG;
				if (lp_active) begin
					state_d = MLP_SHED;
					txdis_d = 1'b1;
					step_d  = 5'h0;
				end else if (class_q > target) begin
					class_d = target;
				end
			end
			MLP_SHED: begin
				// Transmitters go off first, then power steps down.
				txdis_d = 1'b1;
				if (step_q == MLP_STEP_LAST) begin
					step_d = 5'h0;
					if (class_q > MLP_CLASS_1) begin
						class_d = class_q - 3'h1;
					end else begin
						hpen_d  = 1'b0;
						state_d = MLP_LOW;
					end
				end else begin
					step_d = step_q + 5'h1;
				end
			end
			default: begin
				state_d = MLP_LOW;
				class_d = MLP_CLASS_1;
				hpen_d  = 1'b0;
				txdis_d = 1'b1;
				step_d  = 5'h0;
			end
		endcase
		// A rating lowered in mid-run caps the class at once in any state.
		if (class_d > target)
			class_d = target;
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q <= MLP_LOW;
			step_q  <= 5'h0;
			class_q <= MLP_CLASS_1;
			hpen_q  <= 1'b0;
			txdis_q <= 1'b1;
		end else begin
			state_q <= state_d;
			step_q  <= step_d;
			class_q <= class_d;
			hpen_q  <= hpen_d;
			txdis_q <= txdis_d;
		end
	end

	// Watchdog on the transition time; flags a shed that overruns.
	always_comb begin
		wdog_d = 17'h0;
		late_d = late_q;
		if (state_q == MLP_SHED) begin
			wdog_d = wdog_q + 17'h1;
			if (wdog_q >= 17'(THPLP_CYC - 1))
				late_d = 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wdog_q <= 17'h0;
			late_q <= 1'b0;
		end else begin
			wdog_q <= wdog_d;
			late_q <= late_d;
		end
	end

	// The class byte reflects the legal rated class a cycle later, and reads zero in reset.
	always_comb begin
		if (MGMT_ADDR == MLP_REG_CLASS_ID)
			rdata_d = {5'h0, target};
		else
			rdata_d = 8'h00;
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end

	assign MGMT_RDATA      = rdata_q;
	assign POWER_CLASS     = class_q;
	assign HIGH_POWER_EN   = hpen_q;
	assign TX_DISABLE      = txdis_q;
	assign TRANSITION_LATE = late_q;
endmodule

// ==== verilog/mlp_pkg.sv ====
// Package of constants and types for the module low-power presence control.
package mlp_pkg;

	// Power classes, lowest first.
	localparam logic [2:0] MLP_CLASS_1       = 3'h1;
	localparam logic [2:0] MLP_CLASS_MAX     = 3'h5;

	// Power class identification byte, readable over the management bus.
	localparam logic [7:0] MLP_REG_CLASS_ID  = 8'h83;

	// Clock period and the high-to-low power transition limit.
	localparam int         MLP_CLK_PS        = 4000;
	localparam int         MLP_THPLP_US      = 200;
	localparam int         MLP_THPLP_CYC     = (MLP_THPLP_US * 1000000) /
		MLP_CLK_PS;
	// Shed sequence is well inside the limit; this many cycles per step.
	localparam int         MLP_STEP_CYC      = 16;
	localparam logic [4:0] MLP_STEP_LAST     = 5'h0f;
	localparam int         MLP_SYNC_STAGES   = 2;

	typedef enum logic [3:0] {
		MLP_LOW   = 4'h1,
		MLP_RAMP  = 4'h2,
		MLP_HIGH  = 4'h4,
		MLP_SHED  = 4'h8
	} mlp_state_t;

endpackage

// ==== verilog/mlp_sync.sv ====
// Two-stage synchronisers for the low-power and reset pin levels.
`timescale 1ns/100ps
module mlp_sync
	import mlp_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire logic  lowpower_n_in,
	input  wire logic  reset_n_in,
	mlp_sync_if.src    sync
);
	logic [1:0] lp_q;
	logic [1:0] lp_d;
	logic [1:0] rs_q;
	logic [1:0] rs_d;

	always_comb begin
		lp_d = {lp_q[0], lowpower_n_in};
		rs_d = {rs_q[0], reset_n_in};
	end

	// Reset state is asserted so the block sits in low power until sampled.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lp_q <= 2'h0;
			rs_q <= 2'h0;
		end else begin
			lp_q <= lp_d;
			rs_q <= rs_d;
		end
	end

	assign sync.lowpower_n = lp_q[1];
	assign sync.reset_n    = rs_q[1];
endmodule

// ==== verilog/mlp_sync_if.sv ====
// Interface carrying synchronised pin levels between the two modules.
`timescale 1ns/100ps
interface mlp_sync_if;
	logic lowpower_n;
	logic reset_n;

	modport src (output lowpower_n, output reset_n);
	modport dst (input lowpower_n, input reset_n);
endinterface
